// ### design/tec_timer_event_ctrl.sv
// Purpose: Timer event, interrupt and DMA trigger control
// Assumes: Event inputs are one-cycle pulses on clk_sys_i
// Notes: Avalon reads take one wait cycle, writes none
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tec_consts.svh"
module tec_timer_event_ctrl
    import tec_pkg::*;
#(
    parameter int HALF_W = 32
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic mode_match_a_i,
    input wire logic mode_match_b_i,
    input wire logic cap_event_a_i,
    input wire logic cap_match_a_i,
    input wire logic cap_event_b_i,
    input wire logic cap_match_b_i,
    input wire logic rtc_match_i,
    input wire logic dma_done_a_i,
    input wire logic dma_done_b_i,
    output logic irq_o,
    output logic dma_req_a_o,
    output logic dma_req_b_o
);

    ////////////////////////////////////////////////////////////////
    // Helpers
    ////////////////////////////////////////////////////////////////

    // Byte enables to a bit mask
    function automatic word_t be_mask(input logic [3:0] be);
        word_t m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : be_mask

    // Byte-lane merge of a write into a register
    function automatic word_t merge(input word_t old, input word_t nw,
                                   input logic [3:0] be);
        return (old & ~be_mask(be)) | (nw & be_mask(be));
    endfunction : merge

    ////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////

    logic en_a; // Half A running
    logic en_b; // Half B running
    logic full_mode; // One wide counter
    src_vec_t dma_en; // DMA trigger enables
    word_t load_a; // Interval load, half A
    word_t load_b; // Interval load, half B
    word_t lo_hold; // Pending low word of a 64-bit load
    word_t hi_snap; // High word caught by a low-word read
    logic rd_ack; // Read data valid cycle
    word_t wmask; // Lane mask of the current write
    word_t wdat; // Write data under that mask
    logic ld_a_q; // Load A written last cycle
    logic ld_b_q; // Load B written last cycle
    logic run_a_q; // Previous run state, A
    logic run_b_q; // Previous run state, B
    logic run_b; // B counts on its own or as upper half
    logic [HALF_W-1:0] cnt_a; // Counter A
    logic [HALF_W-1:0] cnt_b; // Counter B
    logic zero_a; // Counter A at zero
    logic zero_b; // Counter B at zero
    logic tick_b; // Counter B decrement
    logic to_a; // Timeout A pulse
    logic to_b; // Timeout B pulse
    src_vec_t irq_ev; // Interrupt events
    src_vec_t dma_ev; // DMA trigger events
    src_vec_t raw; // Raw status
    src_vec_t masked; // Masked status
    src_vec_t imask; // Source enables, from the status block
    word_t next_rdata; // Read mux
    logic wr_ld_a; // Write reaches load A
    logic wr_ld_b; // Write reaches load B

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////
    // Bus slave
    ////////////////////////////////////////////////////////////////

    assign wmask = be_mask(byteenable_i);
    assign wdat = writedata_i & wmask;

    // Reads wait one cycle so read data come from a flop
    assign waitrequest_o = read_i & ~rd_ack;

    // Read acknowledge toggles so back-to-back reads each wait
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= read_i & ~rd_ack;
        end
    end

    // Read mux; write-only and unmapped words read zero
    always_comb begin
        next_rdata = '0;
        unique case (address_i)
            `OFF_CTRL: next_rdata = {29'h0, full_mode, en_b, en_a};
            `OFF_DMA_EN: next_rdata = 32'(dma_en);
            `OFF_IMASK: next_rdata = 32'(imask);
            `OFF_RIS: next_rdata = 32'(raw);
            `OFF_MIS: next_rdata = 32'(masked);
            `OFF_LOAD_A: next_rdata = load_a;
            `OFF_LOAD_B: next_rdata = load_b;
            `OFF_LOAD64_LO: next_rdata = load_a;
            `OFF_LOAD64_HI: next_rdata = hi_snap;
            `OFF_CNT_A: next_rdata = 32'(cnt_a);
            `OFF_CNT_B: next_rdata = 32'(cnt_b);
            default: next_rdata = '0;
        endcase
    end

    // Read data latched in the wait cycle, held for the taking edge
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            readdata_o <= `RST_WORD;
        end else if (read_i && !rd_ack) begin
            readdata_o <= next_rdata;
        end
    end

    // Reading the low word freezes the high word for a later read
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hi_snap <= `RST_WORD;
        end else if (read_i && !rd_ack && address_i == `OFF_LOAD64_LO) begin
            hi_snap <= load_b;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control and enables
    ////////////////////////////////////////////////////////////////

    // Enable bits; set and clear words act on named halves only
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            en_a <= 1'b0;
            en_b <= 1'b0;
            full_mode <= 1'b0;
        end else if (write_i) begin
            unique case (address_i)
                `OFF_CTRL: begin
                    if (byteenable_i[0]) begin
                        en_a <= writedata_i[`CTRL_EN_A];
                        en_b <= writedata_i[`CTRL_EN_B];
                        full_mode <= writedata_i[`CTRL_FULL];
                    end
                end
                `OFF_EN_SET: begin
                    en_a <= en_a | wdat[`CTRL_EN_A];
                    en_b <= en_b | wdat[`CTRL_EN_B];
                end
                `OFF_EN_CLR: begin
                    en_a <= en_a & ~wdat[`CTRL_EN_A];
                    en_b <= en_b & ~wdat[`CTRL_EN_B];
                end
                default: begin
                end
            endcase
        end
    end

    // DMA trigger enables
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            dma_en <= '0;
        end else if (write_i && address_i == `OFF_DMA_EN) begin
            // Upper bits of the merged word are not stored
            dma_en <= src_vec_t'(merge(32'(dma_en), writedata_i, byteenable_i));
        end
    end

    ////////////////////////////////////////////////////////////////
    // Load values
    ////////////////////////////////////////////////////////////////

    // In full width the B word is reached only by the high word
    assign wr_ld_a = write_i && (address_i == `OFF_LOAD_A ||
                                 address_i == `OFF_LOAD_BOTH ||
                                 address_i == `OFF_LOAD64_HI);
    assign wr_ld_b = write_i && ((!full_mode && (address_i == `OFF_LOAD_B ||
                                 address_i == `OFF_LOAD_BOTH)) ||
                                 address_i == `OFF_LOAD64_HI);

    // Low word waits for the high word so both change together
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            lo_hold <= `RST_LOAD;
        end else if (write_i && address_i == `OFF_LOAD64_LO) begin
            lo_hold <= merge(lo_hold, writedata_i, byteenable_i);
        end
    end

    // Load A
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            load_a <= `RST_LOAD;
        end else if (write_i && address_i == `OFF_LOAD64_HI) begin
            load_a <= lo_hold;
        end else if (wr_ld_a) begin
            load_a <= merge(load_a, writedata_i, byteenable_i);
        end
    end

    // Load B
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            load_b <= `RST_LOAD;
        end else if (wr_ld_b) begin
            load_b <= merge(load_b, writedata_i, byteenable_i);
        end
    end

    // Load strobes delayed one cycle to see the new value
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ld_a_q <= 1'b0;
            ld_b_q <= 1'b0;
            run_a_q <= 1'b0;
            run_b_q <= 1'b0;
        end else begin
            ld_a_q <= wr_ld_a;
            ld_b_q <= wr_ld_b;
            run_a_q <= en_a;
            run_b_q <= run_b;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Counters
    ////////////////////////////////////////////////////////////////

    // Full width: B is the upper half and follows A's run state
    assign run_b = full_mode ? en_a : en_b;
    assign tick_b = full_mode ? (en_a & zero_a) : en_b;

    tec_half_counter #(.W(HALF_W)) u_cnt_a (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .tick_i(en_a),
        .wrap_i(full_mode & ~zero_b),
        .load_now_i((ld_a_q & en_a) | (en_a & ~run_a_q)),
        .load_val_i(load_a[HALF_W-1:0]),
        .count_o(cnt_a),
        .zero_o(zero_a)
    );

    tec_half_counter #(.W(HALF_W)) u_cnt_b (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .tick_i(tick_b),
        .wrap_i(1'b0),
        .load_now_i((ld_b_q & run_b) | (run_b & ~run_b_q)),
        .load_val_i(load_b[HALF_W-1:0]),
        .count_o(cnt_b),
        .zero_o(zero_b)
    );

    // Timeouts; in full width only A reports, when both halves are zero
    assign to_a = en_a & zero_a & (~full_mode | zero_b) & run_a_q;
    assign to_b = ~full_mode & en_b & zero_b & run_b_q;

    ////////////////////////////////////////////////////////////////
    // Interrupts and DMA triggers
    ////////////////////////////////////////////////////////////////

    // Source order, bit 8 downward
    assign irq_ev = {dma_done_b_i, dma_done_a_i, cap_event_b_i,
                     cap_match_b_i, to_b, rtc_match_i, cap_event_a_i,
                     cap_match_a_i, to_a};
    assign dma_ev = {mode_match_b_i, cap_event_b_i, cap_match_b_i, to_b,
                     mode_match_a_i, rtc_match_i, cap_event_a_i,
                     cap_match_a_i, to_a};

    tec_irq_status #(.N(9)) u_irq (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .event_i(irq_ev),
        .clr_i(write_i && address_i == `OFF_RIS ? wdat[8:0] : 9'h0),
        .mask_wr_i(write_i && address_i == `OFF_IMASK),
        .mask_val_i(src_vec_t'(merge(32'(imask), writedata_i, byteenable_i))),
        .mask_set_i(write_i && address_i == `OFF_IMASK_SET ?
                    wdat[8:0] : 9'h0),
        .mask_clr_i(write_i && address_i == `OFF_IMASK_CLR ?
                    wdat[8:0] : 9'h0),
        .raw_o(raw),
        .masked_o(masked),
        .mask_o(imask),
        .irq_o(irq_o)
    );

    // One-cycle DMA start pulses per half
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            dma_req_a_o <= 1'b0;
            dma_req_b_o <= 1'b0;
        end else begin
            dma_req_a_o <= |(dma_ev[4:0] & dma_en[4:0]);
            dma_req_b_o <= |(dma_ev[8:5] & dma_en[8:5]);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////

    a_dma_start: assert property ((to_a && dma_en[0]) |=> dma_req_a_o)
        else $error("Enabled timeout did not start DMA");
    a_dma_gated: assert property (((dma_ev[8:5] & dma_en[8:5]) == 4'h0)
        |=> !dma_req_b_o)
        else $error("Disabled event started DMA");
    a_dma_readback: assert property ((read_i && rd_ack &&
        address_i == `OFF_DMA_EN) |-> readdata_o == 32'(dma_en))
        else $error("DMA enable readback wrong");
    a_enable_start: assert property ((write_i && address_i == `OFF_EN_SET
        && wdat[`CTRL_EN_A]) |=> en_a ##1 (cnt_a == $past(load_a[HALF_W-1:0])
        || $past(en_a, 2)))
        else $error("Enable did not start half A");
    a_disable_stop: assert property ((write_i && address_i == `OFF_EN_CLR
        && wdat[`CTRL_EN_B] && !full_mode) |=> !en_b ##1 (!to_b && !tick_b))
        else $error("Disable did not stop half B");
    a_mis_read: assert property ((read_i && rd_ack &&
        address_i == `OFF_MIS) |-> readdata_o == 32'($past(masked)))
        else $error("Masked status readback wrong");
    a_load_read: assert property ((read_i && rd_ack &&
        address_i == `OFF_LOAD_A) |-> readdata_o == load_a)
        else $error("Load A readback wrong");
    a_load64_pair: assert property ((write_i &&
        address_i == `OFF_LOAD64_HI) |=> load_a == $past(lo_hold))
        else $error("Wide load words not paired");
    a_full_b_kept: assert property ((write_i && full_mode &&
        address_i == `OFF_LOAD_B) |=> $stable(load_b))
        else $error("Full width load touched half B");
    a_load_immed: assert property ((wr_ld_a && en_a && !full_mode
        && address_i == `OFF_LOAD_A && byteenable_i == 4'hF) ##1 en_a
        |=> cnt_a == $past(writedata_i[HALF_W-1:0], 2))
        else $error("Running load not taken at once");

    c_dma_a: cover property (dma_req_a_o);
    c_full_timeout: cover property (full_mode && to_a);
    c_load64: cover property (write_i && address_i == `OFF_LOAD64_HI);
endmodule : tec_timer_event_ctrl

// ### design/tec_consts.svh
// Operation
// - Nine-bit DMA trigger mask; enabled events start DMA
// - Software reads back the DMA trigger mask
// - Enable starts half A, B or both; in full width setting A starts both, setting B alone starts none
// - Nine interrupt sources, fixed bit layout
// - Only unmasked sources reach the interrupt line
// - Mask-clear write drops only the named bits
// - Clear write deasserts selected raw sources
// - Raw and masked status both readable
// - Per-half load readable; full width uses A
// - Wide full-width load readable as 64 bits
// - Load writes to A, B or both
// - Load while running reaches counter at once
// - Disable stops the selected halves; in full width clearing A stops both, clearing B alone stops none
//
// Purpose: Register offsets, field positions and reset values
// Assumes: 32-bit Avalon-MM slave, byte addresses
// Notes: Definitions only
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_DMA_EN 8'h04
`define OFF_IMASK 8'h08
`define OFF_IMASK_SET 8'h0C
`define OFF_IMASK_CLR 8'h10
`define OFF_RIS 8'h14
`define OFF_MIS 8'h18
`define OFF_LOAD_A 8'h1C
`define OFF_LOAD_B 8'h20
`define OFF_LOAD_BOTH 8'h24
`define OFF_LOAD64_LO 8'h28
`define OFF_LOAD64_HI 8'h2C
`define OFF_CNT_A 8'h30
`define OFF_CNT_B 8'h34
`define OFF_EN_SET 8'h38
`define OFF_EN_CLR 8'h3C
// Control fields
`define CTRL_EN_A 0
`define CTRL_EN_B 1
`define CTRL_FULL 2
// Reset values
`define RST_WORD 32'h0000_0000
`define RST_LOAD 32'hFFFF_FFFF
`endif

// ### design/tec_pkg.sv
// Purpose: Shared types for the timer event block
// Assumes: Nine interrupt and nine DMA sources
// Notes: Bit orders are in the hand-over contract
package tec_pkg;
    typedef logic [31:0] word_t; // Bus word
    typedef logic [8:0] src_vec_t; // One bit per source
endpackage : tec_pkg

// ### design/tec_half_counter.sv
// Purpose: One down-counting timer half
// Assumes: Load has priority over counting
// Notes: Wrap input lets the low half borrow in full width
`timescale 1ns/1ps
module tec_half_counter #(
    parameter int W = 32
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic wrap_i,
    input wire logic load_now_i,
    input wire logic [W-1:0] load_val_i,
    output logic [W-1:0] count_o,
    output logic zero_o
);
    // Counter state
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            count_o <= '0;
        end else if (load_now_i) begin
            count_o <= load_val_i;
        end else if (tick_i) begin
            if (count_o == '0) begin
                // Borrow keeps the wide count exact
                count_o <= wrap_i ? '1 : load_val_i;
            end else begin
                count_o <= count_o - 1'b1;
            end
        end
    end

    assign zero_o = (count_o == '0);
endmodule : tec_half_counter

// ### design/tec_irq_status.sv
// Purpose: Sticky interrupt status, mask and level output
// Assumes: Clear and mask strobes are one-cycle pulses
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
module tec_irq_status #(
    parameter int N = 9
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [N-1:0] event_i,
    input wire logic [N-1:0] clr_i,
    input wire logic mask_wr_i,
    input wire logic [N-1:0] mask_val_i,
    input wire logic [N-1:0] mask_set_i,
    input wire logic [N-1:0] mask_clr_i,
    output logic [N-1:0] raw_o,
    output logic [N-1:0] masked_o,
    output logic [N-1:0] mask_o,
    output logic irq_o
);
    logic [N-1:0] mask; // Source enables

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // Raw status, set over clear
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            raw_o <= '0;
        end else begin
            raw_o <= (raw_o & ~clr_i) | event_i;
        end
    end

    // Mask register
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mask <= '0;
        end else if (mask_wr_i) begin
            mask <= mask_val_i;
        end else begin
            mask <= (mask | mask_set_i) & ~mask_clr_i;
        end
    end

    assign masked_o = raw_o & mask;
    assign mask_o = mask; // Read back and byte merge in the parent
    assign irq_o = |masked_o;

    a_raw_sets: assert property ((event_i != '0) |=>
        ((raw_o & $past(event_i)) == $past(event_i)))
        else $error("Event did not set raw status");
    a_clear_drops: assert property (((clr_i & ~event_i) != '0) |=>
        ((raw_o & $past(clr_i & ~event_i)) == '0))
        else $error("Cleared source still raw");
    a_mask_clr_only: assert property ((!mask_wr_i && mask_clr_i != '0
        && mask_set_i == '0) |=> (mask == ($past(mask) & ~$past(mask_clr_i))))
        else $error("Mask clear touched other bits");
    a_irq_gated: assert property (((raw_o & mask) == '0) |-> !irq_o)
        else $error("Masked source reached interrupt");
    c_irq_rise: cover property ($rose(irq_o));
endmodule : tec_irq_status

// ### sim/tec_far_side_model.sv
// Purpose: DMA controller stand-in that answers trigger pulses
// Assumes: Same clock as the block, triggers are one-cycle pulses
// Notes: Slow mode stretches the answer to show late completion
`timescale 1ns/1ps
module tec_far_side_model (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire logic dma_req_a_i,
    input wire logic dma_req_b_i,
    output logic dma_done_a_o,
    output logic dma_done_b_o
);
    logic [3:0] wait_a; // Cycles left before A finishes
    logic [3:0] wait_b; // Cycles left before B finishes
    //////////////////////////////////////////////////////////////
    // Countdown per channel, done pulses once at the end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wait_a <= 4'h0;
            wait_b <= 4'h0;
            dma_done_a_o <= 1'b0;
            dma_done_b_o <= 1'b0;
        end else begin
            dma_done_a_o <= (wait_a == 4'h1);
            dma_done_b_o <= (wait_b == 4'h1);
            wait_a <= dma_req_a_i ? (slow_i ? 4'h6 : 4'h1) : wait_a - (wait_a != 4'h0);
            wait_b <= dma_req_b_i ? (slow_i ? 4'h6 : 4'h1) : wait_b - (wait_b != 4'h0);
        end
    end
endmodule : tec_far_side_model

// ### sim/tb.sv
// Purpose: Self-checking bench for the timer event block
// Assumes: Avalon reads wait one cycle, writes none
// Notes: Event index follows the DMA enable bit layout
`timescale 1ns/1ps
`include "tec_consts.svh"
module tb;
    import tec_pkg::*;
    logic clk_sys_i = 1'b0; // 25 MHz
    logic reset_i = 1'b1;
    logic [7:0] address_i = 8'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    word_t writedata_i = 32'h0000_0000;
    word_t readdata_o;
    logic waitrequest_o, irq_o, dma_req_a_o, dma_req_b_o, done_a, done_b;
    logic slow = 1'b0; // Partner speed
    logic [8:0] ev = 9'h000; // Event pulses, bits 0 and 5 unused
    int n_fail = 0;
    int compares = 0;
    word_t q; // Last read data
    word_t c0; // Saved count
    int dk[7] = '{1, 2, 3, 4, 6, 7, 8};
    int ik[5] = '{1, 2, 3, 6, 7};
    int ib[5] = '{1, 2, 3, 5, 6};
    always #20 clk_sys_i = ~clk_sys_i;
    tec_timer_event_ctrl u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .byteenable_i(4'hF), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .mode_match_a_i(ev[4]), .mode_match_b_i(ev[8]),
        .cap_event_a_i(ev[2]), .cap_match_a_i(ev[1]), .cap_event_b_i(ev[7]),
        .cap_match_b_i(ev[6]), .rtc_match_i(ev[3]), .dma_done_a_i(done_a),
        .dma_done_b_i(done_b), .irq_o(irq_o), .dma_req_a_o(dma_req_a_o),
        .dma_req_b_o(dma_req_b_o));
    tec_far_side_model u_far (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .slow_i(slow),
        .dma_req_a_i(dma_req_a_o), .dma_req_b_i(dma_req_b_o),
        .dma_done_a_o(done_a), .dma_done_b_o(done_b));
    //////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input word_t got, input word_t exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // One Avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input word_t d);
        int n;
        logic busy;
        n = 0;
        busy = 1'b1;
        @(posedge clk_sys_i);
        write_i <= w;
        read_i <= ~w;
        address_i <= a;
        writedata_i <= d;
        // Waitrequest read mid-cycle, where it has settled
        do begin
            @(negedge clk_sys_i);
            busy = waitrequest_o;
            n++;
            @(posedge clk_sys_i);
        end while (busy !== 1'b0 && n < 20);
        q = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (busy !== 1'b0) begin
            n_fail++;
            end_sim();
        end
    endtask : bus
    task automatic rdc(input string nm, input logic [7:0] a, input word_t exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, q, exp);
    endtask : rdc
    task automatic pulse(input int k);
        @(posedge clk_sys_i);
        ev[k] <= 1'b1;
        @(posedge clk_sys_i);
        ev <= 9'h000;
    endtask : pulse
    //////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc("ctrl", `OFF_CTRL, `RST_WORD);
        rdc("dma_en", `OFF_DMA_EN, `RST_WORD);
        rdc("imask", `OFF_IMASK, `RST_WORD);
        rdc("ris", `OFF_RIS, `RST_WORD);
        rdc("mis", `OFF_MIS, `RST_WORD);
        rdc("load_a", `OFF_LOAD_A, `RST_LOAD);
        rdc("load_b", `OFF_LOAD_B, `RST_LOAD);
        bus(1'b1, 8'h40, 32'hA5A5_A5A5);
        rdc("unmapped", 8'h40, 32'h0000_0000);
    endtask : t_reset
    // Each trigger but bits 0 and 5 alone, then disabled, then all bits
    task automatic t_dma();
        foreach (dk[i]) begin
            slow <= (dk[i] > 5);
            bus(1'b1, `OFF_DMA_EN, 32'h1 << dk[i]);
            rdc("dma_en", `OFF_DMA_EN, 32'h1 << dk[i]);
            pulse(dk[i]);
            @(negedge clk_sys_i);
            chk("req_a", dma_req_a_o, word_t'(dk[i] < 5));
            chk("req_b", dma_req_b_o, word_t'(dk[i] > 5));
        end
        bus(1'b1, `OFF_DMA_EN, 32'h0000_0000);
        pulse(1);
        @(negedge clk_sys_i);
        chk("req_off", dma_req_a_o, 32'h0000_0000);
        bus(1'b1, `OFF_DMA_EN, 32'h0000_01FF);
        rdc("dma_all", `OFF_DMA_EN, 32'h0000_01FF);
        repeat (8) @(posedge clk_sys_i);
        rdc("ris_all", `OFF_RIS, 32'h0000_01EE);
        bus(1'b1, `OFF_RIS, 32'h0000_01EE);
        rdc("ris_clr", `OFF_RIS, 32'h0000_0000);
        bus(1'b1, `OFF_DMA_EN, 32'h0000_0000);
    endtask : t_dma
    task automatic t_irq();
        pulse(1);
        rdc("ris_unmasked", `OFF_RIS, 32'h0000_0002);
        rdc("mis_none", `OFF_MIS, 32'h0000_0000);
        chk("irq_off", irq_o, 32'h0);
        bus(1'b1, `OFF_IMASK_SET, 32'h0000_0102);
        rdc("imask_set", `OFF_IMASK, 32'h0000_0102);
        rdc("mis", `OFF_MIS, 32'h0000_0002);
        chk("irq_on", irq_o, 32'h1);
        bus(1'b1, `OFF_IMASK_CLR, 32'h0000_0002);
        rdc("imask_clr", `OFF_IMASK, 32'h0000_0100);
        chk("irq_masked", irq_o, 32'h0);
        bus(1'b1, `OFF_IMASK_SET, 32'h0000_01FF);
        bus(1'b1, `OFF_RIS, 32'h0000_0002);
        foreach (ik[i]) begin
            pulse(ik[i]);
            @(negedge clk_sys_i);
            chk("irq_src", irq_o, 32'h1);
            rdc("ris_src", `OFF_RIS, 32'h1 << ib[i]);
            bus(1'b1, `OFF_RIS, 32'h1 << ib[i]);
            rdc("ris_gone", `OFF_RIS, 32'h0000_0000);
            chk("irq_gone", irq_o, 32'h0);
        end
        bus(1'b1, `OFF_IMASK, 32'h0000_0000);
    endtask : t_irq
    task automatic t_load();
        bus(1'b1, `OFF_LOAD_A, 32'h0000_1111);
        bus(1'b1, `OFF_LOAD_B, 32'h2222_0000);
        rdc("load_a", `OFF_LOAD_A, 32'h0000_1111);
        rdc("load_b", `OFF_LOAD_B, 32'h2222_0000);
        bus(1'b1, `OFF_LOAD_BOTH, 32'h3333_4444);
        rdc("both_a", `OFF_LOAD_A, 32'h3333_4444);
        rdc("both_b", `OFF_LOAD_B, 32'h3333_4444);
        bus(1'b1, `OFF_CTRL, 32'h0000_0004);
        bus(1'b1, `OFF_LOAD_B, 32'h0000_0000);
        rdc("full_b", `OFF_LOAD_B, 32'h3333_4444);
        bus(1'b1, `OFF_LOAD_BOTH, 32'h5555_6666);
        rdc("full_a", `OFF_LOAD_A, 32'h5555_6666);
        rdc("full_b2", `OFF_LOAD_B, 32'h3333_4444);
        bus(1'b1, `OFF_LOAD64_LO, 32'h1234_5678);
        bus(1'b1, `OFF_LOAD64_HI, 32'h9ABC_DEF0);
        rdc("l64_lo", `OFF_LOAD64_LO, 32'h1234_5678);
        rdc("l64_hi", `OFF_LOAD64_HI, 32'h9ABC_DEF0);
        rdc("l64_a", `OFF_LOAD_A, 32'h1234_5678);
        bus(1'b1, `OFF_CTRL, 32'h0000_0000);
    endtask : t_load
    // Run both halves, reload A on the fly, then stop each
    task automatic t_run();
        int n;
        bus(1'b1, `OFF_LOAD_BOTH, 32'h0000_03E8);
        bus(1'b1, `OFF_EN_SET, 32'h0000_0003);
        rdc("en_both", `OFF_CTRL, 32'h0000_0003);
        bus(1'b0, `OFF_CNT_B, 32'h0000_0000);
        c0 = q;
        bus(1'b0, `OFF_CNT_B, 32'h0000_0000);
        chk("b_runs", word_t'(q < c0), 32'h1);
        bus(1'b1, `OFF_LOAD_A, 32'h0000_0004);
        bus(1'b0, `OFF_CNT_A, 32'h0000_0000);
        chk("a_reload", word_t'(q <= 4), 32'h1);
        bus(1'b1, `OFF_RIS, 32'h0000_01FF);
        n = 0;
        do begin
            bus(1'b0, `OFF_RIS, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b1 && n < 10);
        chk("timeout_a", q[0], 32'h1);
        bus(1'b1, `OFF_EN_CLR, 32'h0000_0001);
        rdc("dis_a", `OFF_CTRL, 32'h0000_0002);
        bus(1'b0, `OFF_CNT_A, 32'h0000_0000);
        c0 = q;
        rdc("a_stopped", `OFF_CNT_A, c0);
        bus(1'b1, `OFF_EN_CLR, 32'h0000_0002);
        rdc("dis_b", `OFF_CTRL, 32'h0000_0000);
    endtask : t_run
    //////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        t_reset();
        t_dma();
        t_irq();
        t_load();
        t_run();
        end_sim();
    end
endmodule : tb
